// file: ecr_regs.sv
// Express capability register bank: subsystem dword, capability header,
// capability register and device capability register behind an APB slave.
// Assumes the power limit strobe comes from logic on CORE_CLK;
// the straps are pins and are synchronised here.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// How it works
// RULE1 - Capability ID 10h in header low byte
// RULE2 - Next pointer F0h links to VPD
// RULE3 - Port type 7 forward, 8 reverse
// RULE4 - Slot implemented zero forward, one reverse
// RULE5 - Phantom functions field reads zero
// RULE6 - Eight-bit tag capability bit reads one
// RULE7 - L0s acceptable latency reads 000
// RULE8 - L1 acceptable latency reads 000
// RULE9 - Attention button only with forward hot-plug
// RULE10 - Indicator bits one with forward hot-plug
// RULE11 - Power limit message captures value and scale
// RULE12 - Subsystem_card_vendor in low half
// RULE13 - Subsystem_card_ident in upper half
// RULE14 - Preceding header points next at B0h
// RULE15 - Writes ignored, reserved bits read zero
// RULE16 - Straps latched at reset, held stable
module ecr_regs #(
  parameter logic [15:0] SUBSYS_VENDOR = 16'h0000, // Arbitrary value.
  parameter logic [15:0] SUBSYS_IDENT  = 16'h0000  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic                    CORE_CLK,
  input  wire logic                    RST_N,
  // APB slave.
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [7:0]              PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  // Strap pins.
  input  wire logic                    STRAP_REVERSE,
  input  wire logic                    STRAP_HOTPLUG,
  // Slot power limit message.
  input  wire logic                    PWR_LIMIT_STB,
  input  wire ecr_pkg::ecr_pwr_limit_t PWR_LIMIT_IN,
  // Strap state seen by the rest of the bridge.
  output logic                         REVERSE_MODE,
  output logic                         HOTPLUG_ON
);
  import ecr_pkg::*;

  logic [1:0]     strap_meta_reg;
  logic [1:0]     strap_sync_reg;
  logic           strap_done_reg;
  ecr_strap_t     strap_reg;
  ecr_pwr_limit_t pwr_reg;
  logic           access_reg;
  logic [31:0]    rdata_next;
  logic           hit_next;

  // Hot-plug presence bits are shared by three fields, so decode once.
  // Reverse bridges never advertise them, whatever the hot-plug strap says.
  function automatic logic hp_present(input ecr_strap_t s);
    hp_present = s.hotplug & ~s.reverse;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Straps are pins, so they pass two flops before anything looks at them.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_meta_reg <= 2'h0;
      strap_sync_reg <= 2'h0;
    end else begin
      strap_meta_reg <= {STRAP_REVERSE, STRAP_HOTPLUG};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Capture once, a few cycles after release, then freeze until reset.
  // The sampling delay gives the synchroniser time to settle.
  logic [1:0] settle_reg;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      settle_reg     <= 2'h0;
      strap_done_reg <= 1'b0;
      strap_reg      <= '0;
    end else if (!strap_done_reg) begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg == ECR_STRAP_SETTLE) begin
        strap_done_reg    <= 1'b1;                // RULE16
        strap_reg.reverse <= strap_sync_reg[1];   // RULE16
        strap_reg.hotplug <= strap_sync_reg[0];   // RULE16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot power limit capture; only the message writes these fields.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwr_reg.value <= ECR_PWR_VAL_RST;
      pwr_reg.scale <= ECR_PWR_SCL_RST;
    end else if (PWR_LIMIT_STB) begin
      pwr_reg <= PWR_LIMIT_IN; // RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux. Every field is read-only, so writes only complete the transfer.
  always_comb begin
    rdata_next = ECR_UNMAPPED_DATA;
    hit_next   = 1'b1;
    case (PADDR)
      ECR_OFS_SUBSYS_HDR: begin
        rdata_next[7:0]   = ECR_SUBSYS_CAP_ID;
        rdata_next[15:8]  = ECR_SUBSYS_NEXT;         // RULE14
        rdata_next[31:16] = 16'h0000;                // RULE15
      end
      ECR_OFS_SUBSYS_ID: begin
        rdata_next[15:0]  = SUBSYS_VENDOR;           // RULE12
        rdata_next[31:16] = SUBSYS_IDENT;            // RULE13
      end
      ECR_OFS_EXP_HDR: begin
        rdata_next[7:0]   = ECR_EXP_CAP_ID;          // RULE1
        rdata_next[15:8]  = ECR_EXP_NEXT;            // RULE2
        rdata_next[19:16] = ECR_CAP_VERSION;
        rdata_next[23:20] = strap_reg.reverse ? ECR_PORT_REVERSE
                                              : ECR_PORT_FORWARD; // RULE3
        rdata_next[24]    = strap_reg.reverse;       // RULE4
        rdata_next[29:25] = ECR_INT_MSG_NUM;
        rdata_next[31:30] = 2'h0;                    // RULE15
      end
      ECR_OFS_DEV_CAP: begin
        rdata_next[2:0]   = ECR_MAX_PAYLOAD;
        rdata_next[4:3]   = ECR_PHANTOM;             // RULE5
        rdata_next[5]     = ECR_EXT_TAG;             // RULE6
        rdata_next[8:6]   = ECR_L0S_LAT;             // RULE7
        rdata_next[11:9]  = ECR_L1_LAT;              // RULE8
        rdata_next[12]    = hp_present(strap_reg);   // RULE9
        rdata_next[13]    = hp_present(strap_reg);   // RULE10
        rdata_next[14]    = hp_present(strap_reg);   // RULE10
        rdata_next[17:15] = 3'h0;                    // RULE15
        rdata_next[25:18] = pwr_reg.value;           // RULE11
        rdata_next[27:26] = pwr_reg.scale;           // RULE11
        rdata_next[31:28] = 4'h0;                    // RULE15
      end
      default: begin
        hit_next = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, so PREADY rises in the second access cycle.
  // PWDATA is deliberately unused; nothing here is writable.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      access_reg <= 1'b0;
      PREADY     <= 1'b0;
      PRDATA     <= 32'h0000_0000;
      PSLVERR    <= 1'b0;
    end else begin
      access_reg <= PSEL & PENABLE & ~PREADY & ~access_reg;
      PREADY     <= PSEL & PENABLE & ~PREADY & ~access_reg;
      if (PSEL & PENABLE & ~PREADY & ~access_reg) begin
        PRDATA  <= PWRITE ? 32'h0000_0000 : rdata_next; // RULE15
        PSLVERR <= ~hit_next;
      end else begin
        PRDATA  <= 32'h0000_0000;
        PSLVERR <= 1'b0;
      end
    end
  end

  // Strap state to the rest of the bridge, from flops.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REVERSE_MODE <= 1'b0;
      HOTPLUG_ON   <= 1'b0;
    end else begin
      REVERSE_MODE <= strap_reg.reverse;
      HOTPLUG_ON   <= strap_reg.hotplug;
    end
  end

endmodule

`default_nettype wire

// file: ecr_pkg.sv
// Package for the express capability register bank: offsets, field values,
// reset values and the packed carriers shared by the design and its bench.
// Assumes a 32-bit APB register port with word-aligned byte addresses.
package ecr_pkg;

  // Register byte offsets.
  localparam logic [7:0] ECR_OFS_SUBSYS_HDR = 8'ha8;
  localparam logic [7:0] ECR_OFS_SUBSYS_ID  = 8'hac;
  localparam logic [7:0] ECR_OFS_EXP_HDR    = 8'hb0;
  localparam logic [7:0] ECR_OFS_DEV_CAP    = 8'hb4;

  // Subsystem header constants (low half of the dword at 0xa8).
  localparam logic [7:0] ECR_SUBSYS_CAP_ID  = 8'h0d;
  localparam logic [7:0] ECR_SUBSYS_NEXT    = 8'hb0;

  // Express capability header fields.
  localparam logic [7:0] ECR_EXP_CAP_ID     = 8'h10;
  localparam logic [7:0] ECR_EXP_NEXT       = 8'hf0;
  localparam logic [3:0] ECR_CAP_VERSION    = 4'h1;
  localparam logic [3:0] ECR_PORT_FORWARD   = 4'h7;
  localparam logic [3:0] ECR_PORT_REVERSE   = 4'h8;
  localparam logic [4:0] ECR_INT_MSG_NUM    = 5'h00;

  // Device capability fields.
  localparam logic [2:0] ECR_MAX_PAYLOAD    = 3'h1;
  localparam logic [1:0] ECR_PHANTOM        = 2'h0;
  localparam logic       ECR_EXT_TAG        = 1'h1;
  localparam logic [2:0] ECR_L0S_LAT        = 3'h0;
  localparam logic [2:0] ECR_L1_LAT         = 3'h0;
  localparam logic [7:0] ECR_PWR_VAL_RST    = 8'h00;
  localparam logic [1:0] ECR_PWR_SCL_RST    = 2'h0;

  // Settle count before the synchronised straps are captured.
  localparam logic [1:0] ECR_STRAP_SETTLE   = 2'h3;

  // Answer to an unmapped address.
  localparam logic [31:0] ECR_UNMAPPED_DATA = 32'h0000_0000;

  // Straps captured a few cycles after reset release.
  typedef struct packed {
    logic reverse;
    logic hotplug;
  } ecr_strap_t;

  // Captured slot power limit.
  typedef struct packed {
    logic [1:0] scale;
    logic [7:0] value;
  } ecr_pwr_limit_t;

endpackage

// file: ecr_pwr_src.sv
// Power limit message source.
// Assumes the bench calls send.
`timescale 1ns/10ps
`default_nettype none
module ecr_pwr_src (
  // Clock and message.
  input  wire logic               clk,
  output logic                    stb,
  output ecr_pkg::ecr_pwr_limit_t lim
);
  import ecr_pkg::*;
  // Idle lines.
  initial begin
    stb = 1'b0;
    lim = '0;
  end
  // Lines flip after the strobe, so stale data never looks valid.
  task automatic send(input logic [9:0] v);
    @(posedge clk);
    stb <= 1'b1;
    lim <= v;
    @(posedge clk);
    stb <= 1'b0;
    lim <= ~v;
  endtask
endmodule
`default_nettype wire

// file: ecr_regs_asserts.sv
// Checker on the register bank ports.
// Assumes the bind below.
`timescale 1ns/10ps
`default_nettype none
module ecr_chk (
  // Clock, reset and bus.
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Power limit and straps.
  input wire logic        PWR_LIMIT_STB,
  input wire ecr_pkg::ecr_pwr_limit_t PWR_LIMIT_IN,
  input wire logic        REVERSE_MODE,
  input wire logic        HOTPLUG_ON
);
  import ecr_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic [9:0] pwr_q;
  wire        rd = PREADY && !PWRITE;
  // Last captured limit, so a read at any later time can be judged.
  always_ff @(posedge CORE_CLK or negedge RST_N)
    if (!RST_N) pwr_q <= '0;
    else if (PWR_LIMIT_STB) pwr_q <= PWR_LIMIT_IN;
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready");
  a_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("wait");
  a_idle_zero: assert property (!PREADY |-> PRDATA == 0) else $error("idle");
  a_cap_header: assert property (
    rd && PADDR == 8'hb0 |-> PRDATA[15:0] == 16'hf010) else $error("header");
  a_port_type: assert property (
    rd && PADDR == 8'hb0 |-> PRDATA[31:16] == {7'h0, REVERSE_MODE,
    REVERSE_MODE ? 4'h8 : 4'h7, 4'h1}) else $error("port");
  a_dev_fixed: assert property (
    rd && PADDR == 8'hb4 |-> PRDATA[11:0] == 12'h021 && PRDATA[31:28] == 0
    && PRDATA[17:15] == 0) else $error("devcap");
  a_hp_bits: assert property (
    rd && PADDR == 8'hb4 |-> PRDATA[14:12] == {3{HOTPLUG_ON && !REVERSE_MODE}})
    else $error("hotplug");
  a_pwr_field: assert property (
    rd && PADDR == 8'hb4 |-> PRDATA[27:18] == pwr_q) else $error("power");
  a_unmapped_err: assert property (
    PREADY && !(PADDR inside {8'ha8, 8'hac, 8'hb0, 8'hb4}) |-> PSLVERR && PRDATA == 0)
    else $error("unmapped");
endmodule
bind ecr_regs ecr_chk chk_u (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .PWR_LIMIT_STB(PWR_LIMIT_STB), .PWR_LIMIT_IN(PWR_LIMIT_IN),
  .REVERSE_MODE(REVERSE_MODE), .HOTPLUG_ON(HOTPLUG_ON));
`default_nettype wire

// file: tb.sv
// Self-checking bench for the register bank.
// Assumes the package, design, checker and source come first.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ecr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, srev = 1'b0, shp = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, rev_m, hp_m, stb, h;
  ecr_pwr_limit_t lim;
  logic [9:0] v;
  logic [33:0] expq[$], e;
  int miscompares = 0, checks = 0;
  always #5 clk = ~clk;
  ecr_regs #(.SUBSYS_VENDOR(16'h5a3c), .SUBSYS_IDENT(16'hc3a5)) dut_u (.CORE_CLK(clk),
    .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .STRAP_REVERSE(srev),
    .STRAP_HOTPLUG(shp), .PWR_LIMIT_STB(stb), .PWR_LIMIT_IN(lim), .REVERSE_MODE(rev_m),
    .HOTPLUG_ON(hp_m));
  ecr_pwr_src src_u (.clk(clk), .stb(stb), .lim(lim));
  task automatic compare(input logic [32:0] x, input logic [32:0] a);
    checks++;
    if (a !== x) begin
      miscompares++;
      $display("FAIL %0t got %h want %h", $time, a, x);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One APB transfer; write data is random since writes must not matter.
  task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] x);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= $urandom;
    expq.push_back({w, x});
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Answers pair with the oldest note; write data is not judged.
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      e = expq.size() > 0 ? expq.pop_front() : 34'h3_ffff_ffff;
      compare(e[32:0], {pslverr, e[33] ? 32'h0 : prdata});
    end
  end
  // Each pass resets with new straps, then flips the pins to prove they were latched.
  initial begin
    void'($urandom(32'h7e2b5c0d));
    for (int m = 0; m < 4; m++) begin
      rst_n <= 1'b0;
      srev <= m[0];
      shp <= m[1];
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      compare({31'h0, m[0], m[1]}, {31'h0, rev_m, hp_m});
      v = 10'($urandom);
      h = m[1] & ~m[0];
      srev <= ~m[0];
      shp <= ~m[1];
      apb(1'b0, 8'ha8, 33'h0_0000_b00d);
      apb(1'b0, 8'hac, 33'h0_c3a5_5a3c);
      apb(1'b1, 8'hb0, 33'h0);
      apb(1'b0, 8'hb0, {8'h0, m[0], m[0] ? 4'h8 : 4'h7, 20'h1f010});
      apb(1'b0, 8'hb4, {18'h0, {3{h}}, 12'h021});
      src_u.send(v);
      apb(1'b1, 8'hb4, 33'h0);
      apb(1'b0, 8'hb4, {5'h0, v, 3'h0, {3{h}}, 12'h021});
      apb(1'b0, 8'hb8, {1'b1, 32'h0});
      apb(1'b1, 8'h00, {1'b1, 32'h0});
      compare({31'h0, m[0], m[1]}, {31'h0, rev_m, hp_m});
      $display("test %0d done", m);
    end
    complete_run;
  end
  // Whole run needs about 200 cycles.
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    complete_run;
  end
endmodule
`default_nettype wire
